/* File: logic/axis_aux_pkg.sv */
package axis_aux_pkg;

  // geometry
  localparam int N_AXES = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ENC_W = 32;
  localparam int MFI_SEL_W = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] SERVO_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] IO_STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MFO_MODE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] MFO_LEVEL_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] PULSER_EN_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] ESTOP_CMD_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] GROUP_CMD_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] MFI_SEL_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h24;
  // compare values sit in page CMP_PAGE, one word per axis
  localparam logic [2:0] CMP_PAGE = 3'h2;

  // field positions
  localparam int GO_DRIVE_BIT = 0;
  localparam int HALT_DRIVE_BIT = 1;
  localparam int STAT_READY_LSB = 0;
  localparam int STAT_MFI_LSB = 8;
  localparam int STAT_GO_BIT = 16;
  localparam int STAT_HALT_BIT = 17;
  localparam int IRQ_DEV_LSB = 0;
  localparam int IRQ_CMP_LSB = 8;
  localparam int IRQ_GO_BIT = 16;
  localparam int IRQ_HALT_BIT = 17;
  localparam int IRQ_W = 18;

  // reset values
  localparam logic [N_AXES-1:0] AXIS_BITS_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 18'h00000;
  localparam logic [ENC_W-1:0] CMP_VAL_RST = 32'h00000000;
  localparam logic [N_AXES*MFI_SEL_W-1:0] MFI_SEL_RST = 24'h000000;

  // timing
  localparam int CLK_MHZ = 50;
  localparam int DEV_CLEAR_US = 10;
  localparam int DEV_CLEAR_CYC = DEV_CLEAR_US * CLK_MHZ;
  localparam int CMP_PULSE_NS = 1000;
  localparam int CMP_PULSE_CYC = (CMP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DEV_CNT_W = 10;
  localparam int CMP_CNT_W = 7;

  // multi-function input selection
  typedef enum logic [MFI_SEL_W-1:0] {
    MFI_GENERAL = 3'b000,
    MFI_LATCH = 3'b001,
    MFI_SLOW = 3'b010,
    MFI_OVERRIDE = 3'b011,
    MFI_ZERO = 3'b100,
    MFI_EMERGENCY = 3'b101
  } mfi_func_t;

endpackage : axis_aux_pkg

/* File: logic/sync_2ff.sv */
`timescale 1ns/1ns
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // idle level of each pin, so no false edge follows reset
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sync_2ff

/* File: logic/pulser_decoder.sv */
`timescale 1ns/1ns
module pulser_decoder (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // synchronised phases
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  // decoded count
  output logic step_o,
  output logic dir_o
);

  logic a_q;
  logic b_q;
  logic moved;
  logic valid;

  // one phase changed: a legal quarter step; both changed: skipped, dropped
  assign moved = (phase_a_i ^ a_q) | (phase_b_i ^ b_q);
  assign valid = moved & ~((phase_a_i ^ a_q) & (phase_b_i ^ b_q));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      step_o <= 1'b0;
      dir_o <= 1'b0;
    end else begin
      a_q <= phase_a_i;
      b_q <= phase_b_i;
      step_o <= valid;
      if (valid) begin
        dir_o <= a_q ^ phase_b_i;
      end
    end
  end

endmodule : pulser_decoder

/* File: logic/axis_aux_io_logic.sv */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module axis_aux_io_logic
  import axis_aux_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic irq_o,
  // motion core
  input wire logic [N_AXES-1:0] home_done_i,
  input wire logic [N_AXES*ENC_W-1:0] enc_count_i,
  // driver and switch pins
  input wire logic [N_AXES-1:0] end_limit_pos_i,
  input wire logic [N_AXES-1:0] end_limit_neg_i,
  input wire logic [N_AXES-1:0] alarm_i,
  input wire logic [N_AXES-1:0] driver_ready_i,
  input wire logic [N_AXES-1:0] multi_input_i,
  output logic [N_AXES-1:0] deviation_clear_o,
  output logic [N_AXES-1:0] servo_enable_o,
  output logic [N_AXES-1:0] multi_output_o,
  output logic [N_AXES-1:0] pulse_inhibit_o,
  // multi-function input results
  output logic [N_AXES-1:0] latch_capture_o,
  output logic [N_AXES-1:0] slow_down_o,
  output logic [N_AXES-1:0] target_override_o,
  output logic [N_AXES-1:0] counter_zero_o,
  output logic [N_AXES-1:0] emergency_input_o,
  // manual pulser
  input wire logic pulser_phase_a_i,
  input wire logic pulser_phase_b_i,
  output logic [N_AXES-1:0] pulser_step_o,
  output logic [N_AXES-1:0] pulser_dir_o,
  // shared start and stop lines, active low
  input wire logic group_go_n_i,
  output logic group_go_o,
  output logic group_go_oe_o,
  input wire logic group_halt_n_i,
  output logic group_halt_o,
  output logic group_halt_oe_o,
  output logic [N_AXES-1:0] group_go_axis_o,
  output logic [N_AXES-1:0] group_halt_axis_o
);

  localparam int SYNC_W = 5 * N_AXES + 4;
  localparam logic [DEV_CNT_W-1:0] DEV_LOAD = DEV_CLEAR_CYC[DEV_CNT_W-1:0];
  localparam logic [CMP_CNT_W-1:0] CMP_LOAD = CMP_PULSE_CYC[CMP_CNT_W-1:0];

  function automatic logic [N_AXES-1:0] rise(input logic [N_AXES-1:0] cur,
                                             input logic [N_AXES-1:0] prev);
    rise = cur & ~prev;
  endfunction : rise

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_out;
  logic [N_AXES-1:0] lim_pos_s;
  logic [N_AXES-1:0] lim_neg_s;
  logic [N_AXES-1:0] alarm_s;
  logic [N_AXES-1:0] ready_s;
  logic [N_AXES-1:0] mfi_s;
  logic pha_s;
  logic phb_s;
  logic go_n_s;
  logic halt_n_s;

  assign sync_raw = {group_halt_n_i, group_go_n_i, pulser_phase_b_i, pulser_phase_a_i,
                     multi_input_i, driver_ready_i, alarm_i, end_limit_neg_i, end_limit_pos_i};
  assign {halt_n_s, go_n_s, phb_s, pha_s, mfi_s, ready_s, alarm_s, lim_neg_s, lim_pos_s}
    = sync_out;

  sync_2ff #(
    .WIDTH(SYNC_W),
    // shared lines idle high, so reset shows them released
    .RST_VAL({2'b11, {(SYNC_W - 2){1'b0}}})
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(sync_raw),
    .sync_o(sync_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  logic wr_servo;
  logic wr_mode;
  logic wr_level;
  logic wr_pen;
  logic wr_estop;
  logic wr_group;
  logic wr_sel;
  logic wr_mask;
  logic rd_stat;
  logic cmp_hit;
  logic [2:0] cmp_idx;

  assign cmp_hit = (addr_i[7:5] == CMP_PAGE) && (addr_i[1:0] == 2'h0);
  assign cmp_idx = addr_i[4:2];
  assign wr_servo = wr_en_i && (addr_i == SERVO_CTRL_OFS);
  assign wr_mode = wr_en_i && (addr_i == MFO_MODE_OFS);
  assign wr_level = wr_en_i && (addr_i == MFO_LEVEL_OFS);
  assign wr_pen = wr_en_i && (addr_i == PULSER_EN_OFS);
  assign wr_estop = wr_en_i && (addr_i == ESTOP_CMD_OFS);
  assign wr_group = wr_en_i && (addr_i == GROUP_CMD_OFS);
  assign wr_sel = wr_en_i && (addr_i == MFI_SEL_OFS);
  assign wr_mask = wr_en_i && (addr_i == IRQ_MASK_OFS);
  assign rd_stat = rd_en_i && (addr_i == IRQ_STATUS_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [N_AXES-1:0] servo_q;
  logic [N_AXES-1:0] mode_q;
  logic [N_AXES-1:0] level_q;
  logic [N_AXES-1:0] pen_q;
  logic [N_AXES-1:0] estop_q;
  logic [1:0] group_q;
  logic [N_AXES*MFI_SEL_W-1:0] sel_q;
  logic [IRQ_W-1:0] mask_q;
  logic [ENC_W-1:0] cmp_val_q [N_AXES];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      servo_q <= AXIS_BITS_RST;
      mode_q <= AXIS_BITS_RST;
      level_q <= AXIS_BITS_RST;
      pen_q <= AXIS_BITS_RST;
      group_q <= 2'h0;
      sel_q <= MFI_SEL_RST;
      mask_q <= IRQ_RST;
    end else begin
      if (wr_servo) servo_q <= wdata_i[N_AXES-1:0];
      if (wr_mode) mode_q <= wdata_i[N_AXES-1:0];
      if (wr_level) level_q <= wdata_i[N_AXES-1:0];
      if (wr_pen) pen_q <= wdata_i[N_AXES-1:0];
      if (wr_group) group_q <= wdata_i[1:0];
      if (wr_sel) sel_q <= wdata_i[N_AXES*MFI_SEL_W-1:0];
      if (wr_mask) mask_q <= wdata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      estop_q <= AXIS_BITS_RST;
    end else begin
      estop_q <= wr_estop ? wdata_i[N_AXES-1:0] : AXIS_BITS_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge history
  logic [N_AXES-1:0] lim_q;
  logic [N_AXES-1:0] alarm_q;
  logic [N_AXES-1:0] mfi_q;
  logic [N_AXES-1:0] eq_q;
  logic go_q;
  logic halt_q;
  logic [N_AXES-1:0] lim_any;
  logic [N_AXES-1:0] eq;
  logic go_seen;
  logic halt_seen;

  assign go_seen = ~go_n_s;
  assign halt_seen = ~halt_n_s;
  assign lim_any = lim_pos_s | lim_neg_s;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim_q <= AXIS_BITS_RST;
      alarm_q <= AXIS_BITS_RST;
      mfi_q <= AXIS_BITS_RST;
      eq_q <= AXIS_BITS_RST;
      go_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      lim_q <= lim_any;
      alarm_q <= alarm_s;
      mfi_q <= mfi_s;
      eq_q <= eq;
      go_q <= go_seen;
      halt_q <= halt_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-axis deviation clear and compare output
  logic [N_AXES-1:0] dev_trig;
  logic [N_AXES-1:0] cmp_trig;

  assign dev_trig = home_done_i | rise(lim_any, lim_q) | rise(alarm_s, alarm_q) | estop_q;
  assign cmp_trig = rise(eq, eq_q) & mode_q;

  for (genvar i = 0; i < N_AXES; i++) begin : g_axis
    logic [DEV_CNT_W-1:0] dev_cnt_q;
    logic [DEV_CNT_W-1:0] dev_cnt_d;
    logic [CMP_CNT_W-1:0] cmp_cnt_q;
    logic [CMP_CNT_W-1:0] cmp_cnt_d;

    assign eq[i] = enc_count_i[i*ENC_W +: ENC_W] == cmp_val_q[i];
    assign dev_cnt_d = dev_trig[i] ? DEV_LOAD :
                       (dev_cnt_q != '0) ? dev_cnt_q - 1'b1 : dev_cnt_q;
    assign cmp_cnt_d = cmp_trig[i] ? CMP_LOAD :
                       (cmp_cnt_q != '0) ? cmp_cnt_q - 1'b1 : cmp_cnt_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cmp_val_q[i] <= CMP_VAL_RST;
      end else if (wr_en_i && cmp_hit && (cmp_idx == 3'(i))) begin
        cmp_val_q[i] <= wdata_i;
      end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dev_cnt_q <= '0;
        deviation_clear_o[i] <= 1'b0;
      end else begin
        dev_cnt_q <= dev_cnt_d;
        deviation_clear_o[i] <= dev_cnt_d != '0;
      end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cmp_cnt_q <= '0;
        multi_output_o[i] <= 1'b0;
      end else begin
        cmp_cnt_q <= cmp_cnt_d;
        multi_output_o[i] <= mode_q[i] ? (cmp_cnt_d != '0) : level_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multi-function inputs
  logic [N_AXES-1:0] mfi_rise;
  logic [N_AXES-1:0] f_latch;
  logic [N_AXES-1:0] f_slow;
  logic [N_AXES-1:0] f_over;
  logic [N_AXES-1:0] f_zero;
  logic [N_AXES-1:0] f_emergency;

  assign mfi_rise = rise(mfi_s, mfi_q);

  for (genvar j = 0; j < N_AXES; j++) begin : g_mfi
    logic [MFI_SEL_W-1:0] sel;
    assign sel = sel_q[j*MFI_SEL_W +: MFI_SEL_W];
    assign f_latch[j] = (sel == MFI_LATCH) & mfi_rise[j];
    assign f_slow[j] = (sel == MFI_SLOW) & mfi_s[j];
    assign f_over[j] = (sel == MFI_OVERRIDE) & mfi_rise[j];
    assign f_zero[j] = (sel == MFI_ZERO) & mfi_rise[j];
    assign f_emergency[j] = (sel == MFI_EMERGENCY) & mfi_s[j];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_capture_o <= AXIS_BITS_RST;
      slow_down_o <= AXIS_BITS_RST;
      target_override_o <= AXIS_BITS_RST;
      counter_zero_o <= AXIS_BITS_RST;
      emergency_input_o <= AXIS_BITS_RST;
    end else begin
      latch_capture_o <= f_latch;
      slow_down_o <= f_slow;
      target_override_o <= f_over;
      counter_zero_o <= f_zero;
      emergency_input_o <= f_emergency;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // manual pulser
  logic p_step;
  logic p_dir;

  pulser_decoder u_pulser (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .phase_a_i(pha_s),
    .phase_b_i(phb_s),
    .step_o(p_step),
    .dir_o(p_dir)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulser_step_o <= AXIS_BITS_RST;
      pulser_dir_o <= AXIS_BITS_RST;
    end else begin
      pulser_step_o <= {N_AXES{p_step}} & pen_q;
      pulser_dir_o <= {N_AXES{p_dir}} & pen_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs and shared lines
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      servo_enable_o <= AXIS_BITS_RST;
      pulse_inhibit_o <= AXIS_BITS_RST;
      group_go_o <= 1'b0;
      group_halt_o <= 1'b0;
      group_go_oe_o <= 1'b0;
      group_halt_oe_o <= 1'b0;
      group_go_axis_o <= AXIS_BITS_RST;
      group_halt_axis_o <= AXIS_BITS_RST;
    end else begin
      servo_enable_o <= servo_q;
      pulse_inhibit_o <= alarm_s;
      group_go_o <= 1'b0;
      group_halt_o <= 1'b0;
      group_go_oe_o <= group_q[GO_DRIVE_BIT];
      group_halt_oe_o <= group_q[HALT_DRIVE_BIT];
      group_go_axis_o <= {N_AXES{go_seen}};
      group_halt_axis_o <= {N_AXES{halt_seen}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, cleared by read, set wins
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] stat_d;

  assign irq_ev = {halt_seen & ~halt_q, go_seen & ~go_q, cmp_trig, dev_trig};
  assign stat_d = irq_ev | (rd_stat ? IRQ_RST : stat_q);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_q <= IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_o <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [DATA_W-1:0] io_stat;
  logic [DATA_W-1:0] rd_mux;

  assign io_stat = {14'h0000, halt_seen, go_seen, mfi_s, ready_s};

  always_comb begin
    rd_mux = 32'h00000000;
    if (cmp_hit) begin
      rd_mux = cmp_val_q[cmp_idx];
    end else begin
      case (addr_i)
        SERVO_CTRL_OFS: rd_mux = {24'h000000, servo_q};
        IO_STATUS_OFS: rd_mux = io_stat;
        MFO_MODE_OFS: rd_mux = {24'h000000, mode_q};
        MFO_LEVEL_OFS: rd_mux = {24'h000000, level_q};
        PULSER_EN_OFS: rd_mux = {24'h000000, pen_q};
        GROUP_CMD_OFS: rd_mux = {30'h00000000, group_q};
        MFI_SEL_OFS: rd_mux = {8'h00, sel_q};
        IRQ_STATUS_OFS: rd_mux = {14'h0000, stat_q};
        IRQ_MASK_OFS: rd_mux = {14'h0000, mask_q};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_en_i ? rd_mux : 32'h00000000;
    end
  end

endmodule : axis_aux_io_logic

/* File: dv/axis_aux_checker_assertions.sv */
`timescale 1ns/1ns
module axis_aux_checker
  import axis_aux_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // axis signals
  input wire logic [N_AXES-1:0] home_done_i,
  input wire logic [N_AXES-1:0] alarm_i,
  input wire logic [N_AXES-1:0] deviation_clear_o,
  input wire logic [N_AXES-1:0] servo_enable_o,
  input wire logic [N_AXES-1:0] pulse_inhibit_o,
  // shared lines
  input wire logic group_go_n_i,
  input wire logic group_halt_n_i,
  input wire logic group_go_o,
  input wire logic group_halt_o,
  input wire logic group_go_oe_o,
  input wire logic group_halt_oe_o,
  input wire logic [N_AXES-1:0] group_go_axis_o,
  input wire logic [N_AXES-1:0] group_halt_axis_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [DEV_CNT_W:0] hi_cnt_q;
  wire servo_wr = wr_en_i && addr_i == SERVO_CTRL_OFS;
  ////////////////////////////////////////
  // length of the current clear pulse on axis 0
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) hi_cnt_q <= '0;
    else if (deviation_clear_o[0]) hi_cnt_q <= hi_cnt_q + 1'b1;
    else hi_cnt_q <= '0;
  end
  sequence estop_wr_s;
    wr_en_i && addr_i == ESTOP_CMD_OFS;
  endsequence
  sequence group_wr_s;
    wr_en_i && addr_i == GROUP_CMD_OFS;
  endsequence
  ////////////////////////////////////////
  rdata_idle_a: assert property (
    !$past(rd_en_i) |-> rdata_o == '0) else $error("read data outside answer cycle");
  stray_read_a: assert property (
    rd_en_i && addr_i == 8'h30 |=> rdata_o == '0) else $error("unmapped read not zero");
  servo_level_a: assert property (
    servo_wr ##1 !servo_wr |=> servo_enable_o == $past(wdata_i[N_AXES-1:0], 2))
    else $error("servo enable not as written");
  estop_clear_a: assert property (
    estop_wr_s |-> ##2 (deviation_clear_o & $past(wdata_i[N_AXES-1:0], 2))
    == $past(wdata_i[N_AXES-1:0], 2)) else $error("stop command gave no clear");
  home_clear_a: assert property (
    |home_done_i |=> (deviation_clear_o & $past(home_done_i)) == $past(home_done_i))
    else $error("home done gave no clear");
  clear_width_a: assert property (
    $fell(deviation_clear_o[0]) |-> hi_cnt_q >= DEV_CLEAR_CYC) else $error("clear too short");
  group_drive_a: assert property (
    group_wr_s |-> ##2 group_go_oe_o == $past(wdata_i[GO_DRIVE_BIT], 2)
    && group_halt_oe_o == $past(wdata_i[HALT_DRIVE_BIT], 2)) else $error("line drive wrong");
  group_low_a: assert property (
    group_go_o == 1'b0 && group_halt_o == 1'b0) else $error("line driven high");
  go_sense_a: assert property (
    $stable(group_go_n_i) [*6] |-> group_go_axis_o == {N_AXES{!group_go_n_i}})
    else $error("start line not seen by axes");
  halt_sense_a: assert property (
    $stable(group_halt_n_i) [*6] |-> group_halt_axis_o == {N_AXES{!group_halt_n_i}})
    else $error("stop line not seen by axes");
  alarm_stop_a: assert property (
    $stable(alarm_i) [*6] |-> pulse_inhibit_o == alarm_i) else $error("alarm not stopping");
endmodule : axis_aux_checker

bind axis_aux_io_logic axis_aux_checker u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .home_done_i(home_done_i),
  .alarm_i(alarm_i), .deviation_clear_o(deviation_clear_o), .servo_enable_o(servo_enable_o),
  .pulse_inhibit_o(pulse_inhibit_o), .group_go_n_i(group_go_n_i),
  .group_halt_n_i(group_halt_n_i), .group_go_o(group_go_o), .group_halt_o(group_halt_o),
  .group_go_oe_o(group_go_oe_o), .group_halt_oe_o(group_halt_oe_o),
  .group_go_axis_o(group_go_axis_o), .group_halt_axis_o(group_halt_axis_o));

/* File: dv/motor_driver_model.sv */
`timescale 1ns/1ns
module motor_driver_model
  import axis_aux_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // device outputs
  input wire logic [N_AXES-1:0] deviation_clear_i,
  input wire logic [N_AXES-1:0] servo_enable_i,
  input wire logic go_oe_i,
  input wire logic halt_oe_i,
  // external switch contacts
  input wire logic ext_go_i,
  input wire logic ext_halt_i,
  // driver and wire state
  output logic [N_AXES-1:0] driver_ready_o,
  output logic [15:0] deviation_o,
  output logic group_go_n_o,
  output logic group_halt_n_o
);
  logic [N_AXES-1:0] ready_q = '0;
  logic [15:0] dev_q = '0;
  ////////////////////////////////////////
  // pulled-up wire, any party only pulls low
  assign group_go_n_o = ~(go_oe_i | ext_go_i);
  assign group_halt_n_o = ~(halt_oe_i | ext_halt_i);
  assign driver_ready_o = ready_q;
  assign deviation_o = dev_q;
  // ready follows servo on a cycle late
  always @(posedge ref_clk_i) begin
    ready_q <= servo_enable_i;
  end
  always @(posedge ref_clk_i) begin
    if (deviation_clear_i[0]) dev_q <= '0;
    else if (servo_enable_i[0]) dev_q <= dev_q + 16'h0001;
  end
endmodule : motor_driver_model

/* File: dv/axis_aux_io_logic_tb.sv */
`timescale 1ns/1ns
module axis_aux_io_logic_tb;
  import axis_aux_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_en_i = 1'b0, rd_en_i = 1'b0, ph_a = 1'b0, ph_b = 1'b0, ext_go = 1'b0, ext_halt = 1'b0;
  logic [N_AXES-1:0] home_done_i = '0, lim_pos = '0, lim_neg = '0, alarm = '0, mfi = '0;
  logic [N_AXES*ENC_W-1:0] enc = '0;
  logic [DATA_W-1:0] rdata_o, v;
  logic irq_o, go_n, halt_n, go_o, go_oe, halt_o, halt_oe;
  logic [N_AXES-1:0] ready, dev_clear, servo, mfo, inhibit, lat, slow, ovr, zero, estop_in;
  logic [N_AXES-1:0] step, dir, go_ax, halt_ax;
  logic [N_AXES-1:0] lat_seen = '0, ovr_seen = '0, zero_seen = '0, dis_seen = '0;
  logic [15:0] drv_dev;
  logic [1:0] seq [8] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01, 2'b11, 2'b10, 2'b00};
  int miscompares = 0, tests_run = 0, cycles = 0, steps0 = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////
  axis_aux_io_logic uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .home_done_i(home_done_i), .enc_count_i(enc), .end_limit_pos_i(lim_pos),
    .end_limit_neg_i(lim_neg), .alarm_i(alarm), .driver_ready_i(ready), .multi_input_i(mfi),
    .deviation_clear_o(dev_clear), .servo_enable_o(servo), .multi_output_o(mfo),
    .pulse_inhibit_o(inhibit), .latch_capture_o(lat), .slow_down_o(slow),
    .target_override_o(ovr), .counter_zero_o(zero), .emergency_input_o(estop_in),
    .pulser_phase_a_i(ph_a), .pulser_phase_b_i(ph_b), .pulser_step_o(step), .pulser_dir_o(dir),
    .group_go_n_i(go_n), .group_go_o(go_o), .group_go_oe_o(go_oe), .group_halt_n_i(halt_n),
    .group_halt_o(halt_o), .group_halt_oe_o(halt_oe), .group_go_axis_o(go_ax),
    .group_halt_axis_o(halt_ax));
  motor_driver_model drv (.ref_clk_i(ref_clk_i), .deviation_clear_i(dev_clear),
    .servo_enable_i(servo), .go_oe_i(go_oe), .halt_oe_i(halt_oe), .ext_go_i(ext_go),
    .ext_halt_i(ext_halt), .driver_ready_o(ready), .deviation_o(drv_dev),
    .group_go_n_o(go_n), .group_halt_n_o(halt_n));
  ////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_en_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rc
  // pulse collectors and hang guard
  always @(posedge ref_clk_i) begin
    lat_seen <= lat_seen | lat;
    ovr_seen <= ovr_seen | ovr;
    zero_seen <= zero_seen | zero;
    dis_seen <= dis_seen | {step[N_AXES-1:1], 1'b0};
    steps0 <= steps0 + int'(step[0]);
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rc(SERVO_CTRL_OFS, 32'h0); // reset value
    rc(MFO_MODE_OFS, 32'h0); // reset value
    wr(8'h30, 32'hFFFFFFFF);
    rc(8'h30, 32'h0); // stray address
    wr(SERVO_CTRL_OFS, 32'hA5);
    tick(8);
    chk(servo, 8'hA5); // servo level
    rc(SERVO_CTRL_OFS, 32'hA5); // readback
    chk(drv_dev != 16'h0, 1'b1); // lag grows
    wr(IRQ_MASK_OFS, 32'h1);
    wr(ESTOP_CMD_OFS, 32'h2);
    tick(4);
    chk(dev_clear, 8'h02); // stop axis 1
    chk(irq_o, 1'b0); // masked event
    wr(ESTOP_CMD_OFS, 32'h1);
    tick(4);
    chk(dev_clear, 8'h03); // stop axis 0
    chk(drv_dev, 16'h0); // lag zeroed
    chk(irq_o, 1'b1); // unmasked event
    rc(IRQ_STATUS_OFS, 32'h3); // sticky bits
    rc(IRQ_STATUS_OFS, 32'h0); // cleared by read
    tick(2);
    chk(irq_o, 1'b0); // irq dropped
    tick(DEV_CLEAR_CYC);
    chk(dev_clear, 8'h00); // pulse ended
    @(posedge ref_clk_i) home_done_i <= 8'h04;
    @(posedge ref_clk_i) home_done_i <= '0;
    tick(1);
    chk(dev_clear, 8'h04); // home done
    @(posedge ref_clk_i) begin
      lim_pos <= 8'h08;
      lim_neg <= 8'h10;
      alarm <= 8'h20;
    end
    tick(6);
    chk(dev_clear, 8'h3C); // limits and alarm
    chk(inhibit, 8'h20); // pulses stopped
    rc(IRQ_STATUS_OFS, 32'h3C); // clear events
    wr(MFO_LEVEL_OFS, 32'h0E);
    tick(2);
    chk(mfo, 8'h0E); // general level
    wr({CMP_PAGE, 5'h00}, 32'h10);
    wr(MFO_MODE_OFS, 32'h1);
    @(posedge ref_clk_i) enc[ENC_W-1:0] <= 32'h10;
    tick(3);
    chk(mfo, 8'h0F); // match pulse
    tick(CMP_PULSE_CYC);
    chk(mfo, 8'h0E); // pulse ended
    rc(IRQ_STATUS_OFS, 32'h100); // match event
    wr(MFI_SEL_OFS, 32'h0002C688);
    @(posedge ref_clk_i) mfi <= 8'h3F;
    tick(6);
    chk({slow, estop_in}, 16'h0420); // level functions
    chk({lat_seen, ovr_seen, zero_seen}, 24'h020810); // pulse functions
    rd(IO_STATUS_OFS, v);
    chk(v[15:0], 16'h3FA5); // input states
    wr(PULSER_EN_OFS, 32'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i) {ph_a, ph_b} <= seq[i];
      tick(8);
      if (i == 3) begin
        chk(steps0, 4); // forward steps
        chk(dir, 8'h00); // forward sense
      end
    end
    chk(steps0, 8); // reverse steps
    chk(dir, 8'h01); // reverse sense, gated
    chk(dis_seen, 8'h00); // disabled axes
    wr(GROUP_CMD_OFS, 32'h1);
    tick(1);
    chk(go_oe, 1'b1); // pulls start line
    tick(5);
    chk(go_ax, 8'hFF); // all axes see start
    rd(IO_STATUS_OFS, v);
    chk(v[17:16], 2'b01); // sensed back
    wr(GROUP_CMD_OFS, 32'h0);
    tick(6);
    chk(go_ax, 8'h00); // released line
    @(posedge ref_clk_i) ext_halt <= 1'b1;
    tick(6);
    chk({halt_oe, halt_ax}, 9'h0FF); // outside pull
    finish_test();
  end
endmodule : axis_aux_io_logic_tb
